// file: fcs_defs.svh
/*
  Offsets, field positions, reset values and codes of the flash
  command sequencer. Assumes inclusion by bare name from design files.
*/
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// Register byte offsets on the peripheral bus port
`define FCS_OFF_CTRL      8'h00
`define FCS_OFF_CMD       8'h04
`define FCS_OFF_STAT      8'h08

// Control register fields and reset value
`define FCS_CTRL_RDYIE    0
`define FCS_CTRL_WS       6
`define FCS_CTRL_RST      32'h0000_0000

// Command register fields
`define FCS_CMD_KEY_HI    31
`define FCS_CMD_KEY_LO    24
`define FCS_CMD_PAGE_HI   23
`define FCS_CMD_PAGE_LO   8
`define FCS_CMD_OP_HI     5
`define FCS_CMD_OP_LO     0

// Status register fields
`define FCS_ST_RDY        0
`define FCS_ST_LOCK_ERROR_FLAG      2
`define FCS_ST_PROG_ERROR_FLAG      3
`define FCS_ST_QUICK_READ_RESULT       5

// Command key and command codes
`define FCS_KEY           8'hA5
`define FCS_OP_WP         6'h01
`define FCS_OP_EP         6'h02
`define FCS_OP_CPB        6'h03
`define FCS_OP_LP         6'h04
`define FCS_OP_UP         6'h05
`define FCS_OP_EA         6'h08
`define FCS_OP_QPR        6'h0C

// Word address bit that selects the User page
`define FCS_USER_BIT      21

`endif

// file: fcs_pkg.sv
/*
  Types shared by the flash command sequencer.
  Assumes nothing of its surroundings.
*/
package fcs_pkg;

  // Command sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_PEND, ST_CLEAR, ST_QPR, ST_FLASH
  } fcs_seq_t;

  // System bus port states
  typedef enum logic [1:0] {
    SB_IDLE, SB_RD1, SB_WR, SB_ACK
  } fcs_sb_t;

endpackage

// file: fcs_pbuf_mem.sv
/*
  Page buffer storage: one write port, one registered read port.
  Assumes a single clock and a clock enable that freezes it.
*/
`timescale 1ns/1ns

module fcs_pbuf_mem #(
  parameter int DW = 32,
  parameter int DEPTH = 128
) (
  input  wire logic                     clk_i,   // Clock
  input  wire logic                     ce_i,    // Clock enable
  input  wire logic                     we_i,    // Write strobe
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i, // Write word index
  input  wire logic [DW-1:0]            wdata_i, // Write data
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i, // Read word index
  output logic      [DW-1:0]            rdata_o  // Registered read data
);

  logic [DW-1:0] mem_reg [DEPTH];

  // Write and registered read
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem_reg[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_reg[raddr_i];
    end
  end

endmodule

// file: fcs_ctrl.sv
/*
  Flash command sequencer: system bus port reads and page buffer writes,
  Wishbone register port, keyed command issue and status flags.
  Assumes one clock, flash array ports that answer in the enable cycle,
  and a flash macro that runs program/erase/lock and pulses done.
*/
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
// Contract
// [R1] Only zero or one wait-state read timing
// [R2] Zero wait states: one read port only
// [R3] One wait state: both ports, next word prefetched
// [R4] Word space 2^21; beyond array is undefined
// [R5] User page at word 2^21, 128 words
// [R6] Quick page read ANDs page into flag
// [R7] Page buffer decoded by low bits, wraps
// [R8] Buffer write updates page number field
// [R9] Masters write buffer with 32-bit words only
// [R10] Buffer writes only clear bits
// [R11] Only clear command sets buffer to ones
// [R12] Software merges page data before word update
// [R13] Command write clears ready; completion sets it
// [R14] Ready interrupt on completion except quick read
// [R15] Command starts on first idle system cycle
// [R16] Masters leave idle system bus cycles
// [R17] Software waits for completion before flash access
// [R18] Bad key or command sets programming error
// [R19] Command while busy sets programming error
// [R20] Protected page write/erase sets lock error
// [R21] Status read clears both error flags
// [R22] Software keeps both port clocks running
// [R23] Status read returns flags before clearing
`timescale 1ns/1ns
`include "fcs_defs.svh"

module fcs_ctrl #(
  parameter int W           = 128,   // Words per page
  parameter int TOTAL_WORDS = 65536  // Words in main array
) (
  input  wire logic              clk_i,        // Clock, 10 MHz
  input  wire logic              rst_i,        // Sync reset, high
  input  wire logic              ce_i,         // Clock enable
  input  wire logic              wb_cyc_i,     // Wishbone cycle
  input  wire logic              wb_stb_i,     // Wishbone strobe
  input  wire logic              wb_we_i,      // Wishbone write
  input  wire logic [7:0]        wb_adr_i,     // Wishbone byte address
  input  wire logic [3:0]        wb_sel_i,     // Wishbone byte lanes
  input  wire logic [31:0]       wb_dat_i,     // Wishbone write data
  output logic      [31:0]       wb_dat_o,     // Wishbone read data
  output logic                   wb_ack_o,     // Wishbone ack
  input  wire logic              sb_req_i,     // System port request
  input  wire logic              sb_we_i,      // System port write
  input  wire logic [21:0]       sb_addr_i,    // System port word addr
  input  wire logic [31:0]       sb_wdata_i,   // System port wr data
  output logic      [31:0]       sb_rdata_o,   // System port rd data
  output logic                   sb_ack_o,     // System port ack
  output logic      [20:0]       fa_addr_o,    // Even port address
  output logic                   fa_en_o,      // Even port enable
  input  wire logic [31:0]       fa_data_i,    // Even port data
  output logic      [20:0]       fb_addr_o,    // Odd port address
  output logic                   fb_en_o,      // Odd port enable
  input  wire logic [31:0]       fb_data_i,    // Odd port data
  output logic                   fl_user_o,    // User page select
  output logic                   fl_start_o,   // Macro command pulse
  output logic      [5:0]        fl_op_o,      // Macro command code
  output logic      [15:0]       fl_page_o,    // Macro page number
  input  wire logic              fl_done_i,    // Macro done pulse
  input  wire logic [$clog2(W)-1:0] fl_pb_addr_i, // Macro buffer index
  output logic      [31:0]       fl_pb_data_o, // Buffer word to macro
  input  wire logic [15:0]       lock_bits_i,  // Region lock bits
  input  wire logic [15:0]       boot_pages_i, // Boot-protected pages
  output logic                   irq_o         // Interrupt line
);

  localparam int WB    = $clog2(W);
  localparam int PAGES = TOTAL_WORDS / W;
  localparam int RSH   = $clog2(PAGES / 16);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Valid command codes
  function automatic logic op_valid(input logic [5:0] op);
    op_valid = (op == `FCS_OP_WP) || (op == `FCS_OP_EP) ||
               (op == `FCS_OP_CPB) || (op == `FCS_OP_LP) ||
               (op == `FCS_OP_UP) || (op == `FCS_OP_EA) ||
               (op == `FCS_OP_QPR);
  endfunction

  // Page locked by its region bit or by boot protection
  function automatic logic page_prot(input logic [15:0] pg,
                                     input logic [15:0] lk,
                                     input logic [15:0] bp);
    logic [15:0] rg;
    rg = pg >> RSH;
    page_prot = lk[rg[3:0]] || (pg < bp);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  fcs_pkg::fcs_seq_t seq_reg;
  fcs_pkg::fcs_sb_t  sb_reg;
  logic              rdyie_reg;
  logic              ws_reg;
  logic              ready_reg;
  logic              prog_error_flag_reg;
  logic              lock_error_flag_reg;
  logic              quick_read_result_reg;
  logic              qacc_reg;
  logic              lastq_reg;
  logic [5:0]        op_reg;
  logic [15:0]       page_reg;
  logic [WB-1:0]     idx_reg;
  logic              pf_valid_reg;
  logic [21:0]       pf_addr_reg;
  logic [31:0]       pf_data_reg;
  logic              wb_ack_reg;
  logic [31:0]       wb_dat_reg;
  logic [31:0]       sb_rdata_reg;
  logic [31:0]       pb_rdata;

  ////////////////////////////////////////////////////////////////////////
  // Register port decode

  wire wb_take  = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  wire sel_ctrl = wb_adr_i == `FCS_OFF_CTRL;
  wire sel_cmd  = wb_adr_i == `FCS_OFF_CMD;
  wire sel_stat = wb_adr_i == `FCS_OFF_STAT;
  wire ctrl_wr  = wb_take & wb_we_i & sel_ctrl & wb_sel_i[0];
  wire cmd_wr   = wb_take & wb_we_i & sel_cmd & (&wb_sel_i);
  wire stat_rd  = wb_take & ~wb_we_i & sel_stat;
  wire [7:0] key_in = wb_dat_i[`FCS_CMD_KEY_HI:`FCS_CMD_KEY_LO];
  wire [5:0] op_in  = wb_dat_i[`FCS_CMD_OP_HI:`FCS_CMD_OP_LO];
  wire key_ok   = key_in == `FCS_KEY;
  wire busy     = seq_reg != fcs_pkg::ST_IDLE;
  wire accept   = cmd_wr & key_ok & op_valid(op_in) & ~busy;
  wire bad_cmd  = cmd_wr & ~(key_ok & op_valid(op_in)) | cmd_wr & busy;

  // Read data view of the registers
  wire [31:0] ctrl_view = {25'd0, ws_reg, 5'd0, rdyie_reg};
  wire [31:0] cmd_view  = {8'd0, page_reg, 2'd0, op_reg};
  wire [31:0] stat_view = {26'd0, quick_read_result_reg, 1'b0, prog_error_flag_reg,
                           lock_error_flag_reg, 1'b0, ready_reg};
  wire [31:0] rd_mux    = sel_ctrl ? ctrl_view :
                          sel_cmd  ? cmd_view  :
                          sel_stat ? stat_view : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // System bus port decode

  wire sb_idle   = sb_reg == fcs_pkg::SB_IDLE;
  wire sb_take   = sb_idle & sb_req_i;
  wire sb_rd     = sb_take & ~sb_we_i;
  wire pf_hit    = ws_reg & pf_valid_reg & (pf_addr_reg == sb_addr_i);
  wire [21:0] nxt_addr = sb_addr_i + 22'h00_0001;
  wire [21:0] ev_addr  = sb_addr_i[0] ? nxt_addr : sb_addr_i;
  wire [21:0] od_addr  = sb_addr_i[0] ? sb_addr_i : nxt_addr;
  wire [15:0] sb_page  = 16'(sb_addr_i[21:WB]);
  wire [31:0] sel_data = sb_addr_i[0] ? fb_data_i : fa_data_i;
  wire [31:0] oth_data = sb_addr_i[0] ? fa_data_i : fb_data_i;
  wire sb_rd_ev  = (sb_rd & ~pf_hit) | (sb_reg == fcs_pkg::SB_RD1);

  // Quick page read walks the page through the interleaved ports
  wire in_qpr   = seq_reg == fcs_pkg::ST_QPR;
  wire [20:0] q_addr = 21'({page_reg, idx_reg});
  wire [31:0] q_data = idx_reg[0] ? fb_data_i : fa_data_i;
  wire idx_last = idx_reg == WB'(W - 1);

  // Array port drive
  assign fa_addr_o = in_qpr ? q_addr : ev_addr[20:0];
  assign fb_addr_o = in_qpr ? q_addr : od_addr[20:0];
  assign fl_user_o = ~in_qpr & sb_addr_i[`FCS_USER_BIT];  // R5 R4
  assign fa_en_o   = in_qpr ? ~idx_reg[0] :
                     sb_rd_ev & (ws_reg | ~sb_addr_i[0]); // R1 R2 R3
  assign fb_en_o   = in_qpr ? idx_reg[0] :
                     sb_rd_ev & (ws_reg | sb_addr_i[0]);  // R2 R3

  ////////////////////////////////////////////////////////////////////////
  // Page buffer access

  wire in_clear = seq_reg == fcs_pkg::ST_CLEAR;
  wire sb_commit = sb_reg == fcs_pkg::SB_WR;
  wire in_flash = seq_reg == fcs_pkg::ST_FLASH;
  wire pb_we = sb_commit | in_clear;
  wire [WB-1:0] pb_waddr = in_clear ? idx_reg : sb_addr_i[WB-1:0]; // R7
  wire [31:0] pb_wdata = in_clear ? 32'hFFFF_FFFF :          // R11
                         pb_rdata & sb_wdata_i;              // R10
  wire [WB-1:0] pb_raddr = in_flash ? fl_pb_addr_i : sb_addr_i[WB-1:0];

  fcs_pbuf_mem #(
    .DW    (32),
    .DEPTH (W)
  ) u_pbuf (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (pb_we),
    .waddr_i (pb_waddr),
    .wdata_i (pb_wdata),
    .raddr_i (pb_raddr),
    .rdata_o (pb_rdata)
  );

  assign fl_pb_data_o = pb_rdata;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer decode

  wire in_pend  = seq_reg == fcs_pkg::ST_PEND;
  wire go       = in_pend & ~sb_req_i & sb_idle;        // R15
  wire is_pg    = (op_reg == `FCS_OP_WP) | (op_reg == `FCS_OP_EP);
  wire is_ea    = op_reg == `FCS_OP_EA;
  wire prot_hit = is_pg & page_prot(page_reg, lock_bits_i, boot_pages_i) |
                  is_ea & ((|lock_bits_i) | (|boot_pages_i));
  wire to_macro = go & ~prot_hit & (is_pg | is_ea |
                  (op_reg == `FCS_OP_LP) | (op_reg == `FCS_OP_UP));
  wire done     = go & prot_hit | in_clear & idx_last |
                  in_qpr & idx_last | in_flash & fl_done_i;
  wire lock_error_flag_set = go & prot_hit;                        // R20
  wire prog_error_flag_set = bad_cmd;                              // R18 R19

  assign fl_start_o = to_macro;
  assign fl_op_o    = op_reg;
  assign fl_page_o  = page_reg;
  assign irq_o = ready_reg & rdyie_reg & ~lastq_reg;     // R14

  ////////////////////////////////////////////////////////////////////////
  // Register port and flags

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
      rdyie_reg  <= 1'b0;
      ws_reg     <= 1'b0;
      prog_error_flag_reg  <= 1'b0;
      lock_error_flag_reg  <= 1'b0;
    end else if (ce_i) begin
      wb_ack_reg <= wb_take;
      if (wb_take) begin
        wb_dat_reg <= rd_mux;                            // R23
      end
      if (ctrl_wr) begin
        rdyie_reg <= wb_dat_i[`FCS_CTRL_RDYIE];
        ws_reg    <= wb_dat_i[`FCS_CTRL_WS];             // R1
      end
      prog_error_flag_reg <= prog_error_flag_set | (prog_error_flag_reg & ~stat_rd);   // R21
      lock_error_flag_reg <= lock_error_flag_set | (lock_error_flag_reg & ~stat_rd);   // R21
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_reg   <= fcs_pkg::ST_IDLE;
      ready_reg <= 1'b1;
      op_reg    <= 6'h00;
      page_reg  <= 16'h0000;
      idx_reg   <= '0;
      qacc_reg  <= 1'b1;
      quick_read_result_reg  <= 1'b0;
      lastq_reg <= 1'b0;
    end else if (ce_i) begin
      if (sb_commit) begin
        page_reg <= sb_page;                             // R8
      end
      if (done) begin
        ready_reg <= 1'b1;                               // R13
        seq_reg   <= fcs_pkg::ST_IDLE;
      end
      case (seq_reg)
        fcs_pkg::ST_IDLE: begin
          if (accept) begin
            seq_reg   <= fcs_pkg::ST_PEND;
            ready_reg <= 1'b0;                           // R13
            op_reg    <= op_in;
            page_reg  <= wb_dat_i[`FCS_CMD_PAGE_HI:`FCS_CMD_PAGE_LO];
            lastq_reg <= op_in == `FCS_OP_QPR;
          end
        end
        fcs_pkg::ST_PEND: begin
          idx_reg  <= '0;
          qacc_reg <= 1'b1;
          if (go & ~prot_hit) begin
            if (op_reg == `FCS_OP_CPB) begin
              seq_reg <= fcs_pkg::ST_CLEAR;
            end else if (op_reg == `FCS_OP_QPR) begin
              seq_reg <= fcs_pkg::ST_QPR;
            end else begin
              seq_reg <= fcs_pkg::ST_FLASH;
            end
          end
        end
        fcs_pkg::ST_CLEAR: begin
          idx_reg <= idx_reg + WB'(1);
        end
        fcs_pkg::ST_QPR: begin
          idx_reg  <= idx_reg + WB'(1);
          qacc_reg <= qacc_reg & (&q_data);              // R6
          if (idx_last) begin
            quick_read_result_reg <= qacc_reg & (&q_data);            // R6
          end
        end
        fcs_pkg::ST_FLASH: begin
        end
        default: begin
          seq_reg <= fcs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // System bus port

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sb_reg       <= fcs_pkg::SB_IDLE;
      sb_rdata_reg <= 32'h0000_0000;
      pf_valid_reg <= 1'b0;
      pf_addr_reg  <= 22'h00_0000;
      pf_data_reg  <= 32'h0000_0000;
    end else if (ce_i) begin
      case (sb_reg)
        fcs_pkg::SB_IDLE: begin
          if (sb_take & sb_we_i) begin
            sb_reg <= fcs_pkg::SB_WR;
          end else if (sb_rd & pf_hit) begin
            sb_rdata_reg <= pf_data_reg;                 // R3
            pf_valid_reg <= 1'b0;
            sb_reg       <= fcs_pkg::SB_ACK;
          end else if (sb_rd & ws_reg) begin
            sb_reg <= fcs_pkg::SB_RD1;
          end else if (sb_rd) begin
            sb_rdata_reg <= sel_data;                    // R2
            sb_reg       <= fcs_pkg::SB_ACK;
          end
        end
        fcs_pkg::SB_RD1: begin
          sb_rdata_reg <= sel_data;
          pf_data_reg  <= oth_data;                      // R3
          pf_addr_reg  <= nxt_addr;
          pf_valid_reg <= 1'b1;
          sb_reg       <= fcs_pkg::SB_ACK;
        end
        fcs_pkg::SB_WR: begin
          sb_reg <= fcs_pkg::SB_ACK;
        end
        fcs_pkg::SB_ACK: begin
          sb_reg <= fcs_pkg::SB_IDLE;
        end
        default: begin
          sb_reg <= fcs_pkg::SB_IDLE;
        end
      endcase
      if (go | ~ws_reg) begin
        pf_valid_reg <= 1'b0;
      end
    end
  end

  assign sb_ack_o   = sb_reg == fcs_pkg::SB_ACK;
  assign sb_rdata_o = sb_rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_ws0_one_port;
    @(posedge clk_i) disable iff (rst_i)
    (~ws_reg & sb_rd & ~in_qpr) |-> (fa_en_o ^ fb_en_o);
  endproperty
  a_ws0_one_port: assert property (p_ws0_one_port) // R2
    else $error("zero wait read used both ports");

  property p_ws1_both;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i & ws_reg & sb_rd & ~pf_hit & ~in_qpr) |=>
      (fa_en_o & fb_en_o) ##1 sb_ack_o;
  endproperty
  a_ws1_both: assert property (p_ws1_both) // R3
    else $error("one wait read not on both ports");

  property p_page_number_field;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i & sb_commit) |=> (page_reg == $past(sb_page));
  endproperty
  a_page_number_field: assert property (p_page_number_field) // R8
    else $error("page field not updated by buffer write");

  property p_ready_clear;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i & accept) |=> ~ready_reg & in_pend;
  endproperty
  a_ready_clear: assert property (p_ready_clear) // R13
    else $error("ready not cleared by command write");

  property p_wait_idle;
    @(posedge clk_i) disable iff (rst_i)
    (in_pend & sb_req_i) |-> ~fl_start_o ##1 (in_pend | ~ce_i);
  endproperty
  a_wait_idle: assert property (p_wait_idle) // R15
    else $error("command started while system port busy");

  property p_bad_key;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i & cmd_wr & ~key_ok) |=> prog_error_flag_reg && $stable(op_reg);
  endproperty
  a_bad_key: assert property (p_bad_key) // R18
    else $error("bad key not flagged or accepted");

  property p_busy_err;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i & cmd_wr & busy) |=> prog_error_flag_reg & busy;
  endproperty
  a_busy_err: assert property (p_busy_err) // R19
    else $error("command while busy not flagged");

  property p_lock_err;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i & go & prot_hit) |-> ~fl_start_o ##1 (lock_error_flag_reg & ready_reg);
  endproperty
  a_lock_err: assert property (p_lock_err) // R20
    else $error("protected page not refused");

  property p_rd_clear;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i & stat_rd & ~prog_error_flag_set & ~lock_error_flag_set) |=>
      ~prog_error_flag_reg & ~lock_error_flag_reg & wb_ack_o;
  endproperty
  a_rd_clear: assert property (p_rd_clear) // R21
    else $error("status read did not clear errors");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    irq_o |-> ready_reg & rdyie_reg & (op_reg != `FCS_OP_QPR);
  endproperty
  a_irq: assert property (p_irq) // R14
    else $error("interrupt without ready or after quick read");

endmodule

// file: fcs_flash_model.sv
/*
  Behavioural flash array and command macro facing the sequencer.
  Assumes one clock; array data answers in the enable cycle.
*/
`timescale 1ns/1ns

module fcs_flash_model #(
  parameter int DONE_DLY = 8  // Macro busy cycles
) (
  input  wire logic        clk_i,      // Clock
  input  wire logic [20:0] fa_addr_i,  // Even port address
  input  wire logic        fa_en_i,    // Even port enable
  input  wire logic [20:0] fb_addr_i,  // Odd port address
  input  wire logic        fb_en_i,    // Odd port enable
  input  wire logic        fl_user_i,  // User page select
  input  wire logic        fl_start_i, // Macro start pulse
  output logic      [31:0] fa_data_o,  // Even port data
  output logic      [31:0] fb_data_o,  // Odd port data
  output logic             fl_done_o,  // Macro done pulse
  output logic      [6:0]  fl_pb_o     // Buffer index read
);
  int cnt = 0;

  // Page 1 erased, others carry their address
  function automatic logic [31:0] f(input logic u, input logic [20:0] a);
    f = (a[20:7] == 14'd1) ? 32'hFFFF_FFFF : {10'h0, u, a};
  endfunction

  // Idle ports show the inverse, never stale data
  assign fa_data_o = fa_en_i ? f(fl_user_i, fa_addr_i)
                             : ~f(fl_user_i, fa_addr_i);
  assign fb_data_o = fb_en_i ? f(fl_user_i, fb_addr_i)
                             : ~f(fl_user_i, fb_addr_i);
  assign fl_pb_o = 7'h02;

  ////////////////////////////////////////////////////////////////////////
  // Done pulse a fixed time after start
  always @(posedge clk_i) begin
    cnt <= fl_start_i ? DONE_DLY : (cnt > 0 ? cnt - 1 : 0);
    fl_done_o <= (cnt == 1);
  end
endmodule

// file: testbench.sv
/*
  Self-checking bench of the flash command sequencer.
  Assumes the flash model beside it and the shared defines.
*/
`timescale 1ns/1ns
`include "fcs_defs.svh"

module testbench;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sreq = 0, swe = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, sdat = 32'h0000_0000, st, q;
  logic [21:0] sadr = 22'h00_0000;
  logic [15:0] lock = 16'h0000;
  logic [31:0] rdat, srd, fa_d, fb_d, pbd;
  logic [20:0] fa_a, fb_a;
  logic [15:0] page;
  logic [6:0]  pbi;
  logic [5:0]  op;
  logic ack, sack, fa_e, fb_e, usr, start, done, irq, ws1 = 0;
  int n_fail = 0, samples_checked = 0, both0 = 0, both1 = 0, starts = 0;
  int s0 = 0;

  always #50 clk_i = ~clk_i;

  fcs_ctrl #(.W(128), .TOTAL_WORDS(65536)) fcs_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sb_req_i(sreq),
    .sb_we_i(swe), .sb_addr_i(sadr), .sb_wdata_i(sdat), .sb_rdata_o(srd),
    .sb_ack_o(sack), .fa_addr_o(fa_a), .fa_en_o(fa_e), .fa_data_i(fa_d),
    .fb_addr_o(fb_a), .fb_en_o(fb_e), .fb_data_i(fb_d), .fl_user_o(usr),
    .fl_start_o(start), .fl_op_o(op), .fl_page_o(page), .fl_done_i(done),
    .fl_pb_addr_i(pbi), .fl_pb_data_o(pbd), .lock_bits_i(lock),
    .boot_pages_i(16'h0000), .irq_o(irq));

  fcs_flash_model fcs_flash_model_inst (
    .clk_i(clk_i), .fa_addr_i(fa_a), .fa_en_i(fa_e), .fb_addr_i(fb_a),
    .fb_en_i(fb_e), .fl_user_i(usr), .fl_start_i(start), .fa_data_o(fa_d),
    .fb_data_o(fb_d), .fl_done_o(done), .fl_pb_o(pbi));

  ////////////////////////////////////////////////////////////////////////
  // Port activity monitors
  always @(posedge clk_i) begin
    if (fa_e && fb_e && !ws1) both0++;
    if (fa_e && fb_e && ws1) both1++;
    if (start) starts++;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Wishbone classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && k++ < 50);
    if (k >= 50) n_fail++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  // System port word access, held until ack
  task automatic sb(input logic w, input logic [21:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    sreq <= 1'b1; swe <= w; sadr <= a; sdat <= d;
    do @(posedge clk_i); while (sack !== 1'b1 && k++ < 50);
    if (k >= 50) n_fail++;
    q = srd;
    sreq <= 1'b0; sadr <= 22'h00_0000;
  endtask

  // Keyed command; poll until ready, keep last status
  task automatic cmd(input logic [7:0] key, input logic [5:0] o, input logic [15:0] p);
    wb(1'b1, `FCS_OFF_CMD, {key, p, 2'b00, o});
  endtask
  task automatic rdy();
    int k;
    k = 0;
    do begin wb(1'b0, `FCS_OFF_STAT, 32'h0000_0000); st = q; end
    while (st[0] !== 1'b1 && k++ < 200);
  endtask

  task automatic t_reads();
    wb(1'b0, `FCS_OFF_CTRL, 32'h0); chk("ctrl", 32'h0, q);
    wb(1'b0, `FCS_OFF_STAT, 32'h0); chk("stat", 32'h1, q & 32'h0000_000D);
    sb(1'b0, 22'h00_0005, 32'h0); chk("rd0ws", 32'h0000_0005, q);
    wb(1'b1, `FCS_OFF_CTRL, 32'h0000_0040); ws1 = 1;
    sb(1'b0, 22'h00_0008, 32'h0); chk("rd1ws", 32'h0000_0008, q);
    sb(1'b0, 22'h00_0009, 32'h0); chk("rdseq", 32'h0000_0009, q);
    sb(1'b0, 22'h20_0003, 32'h0); chk("user", 32'h0020_0003, q);
    chk("both1", 32'h1, both1 != 0);
  endtask

  task automatic t_pbuf();
    cmd(`FCS_KEY, `FCS_OP_CPB, 16'h0); rdy();
    sb(1'b1, 22'h00_0082, 32'hFFFF_00FF); chk("page", 32'h1, page);
    sb(1'b1, 22'h00_0002, 32'h0F0F_FFFF); chk("page", 32'h0, page);
    // Park the port address on word 2 so the buffer read shows it
    @(posedge clk_i);
    sadr <= 22'h00_0002;
    repeat (2) @(posedge clk_i);
    chk("pbuf", 32'h0F0F_00FF, pbd);
    cmd(`FCS_KEY, `FCS_OP_WP, 16'h0); rdy();
    chk("op", `FCS_OP_WP, op);
    chk("pbuf", 32'h0F0F_00FF, pbd);
    cmd(`FCS_KEY, `FCS_OP_CPB, 16'h0); rdy();
    chk("pbuf", 32'hFFFF_FFFF, pbd);
  endtask

  task automatic t_cmds();
    wb(1'b1, `FCS_OFF_CTRL, 32'h0000_0041);
    // Command issued while a system port read is in flight
    fork
      cmd(`FCS_KEY, `FCS_OP_EP, 16'h4);
      sb(1'b0, 22'h00_0010, 32'h0);
    join
    chk("rdbusy", 32'h0000_0010, q);
    wb(1'b0, `FCS_OFF_STAT, 32'h0); chk("rdy", 32'h0, q[0]);
    chk("irq", 32'h0, irq);
    rdy(); chk("rdy", 32'h1, st[0]);
    chk("irq", 32'h1, irq);
    cmd(`FCS_KEY, `FCS_OP_QPR, 16'h1); rdy();
    chk("quick_read_result", 32'h1, st[5]);
    chk("irq", 32'h0, irq);
    cmd(`FCS_KEY, `FCS_OP_QPR, 16'h0); rdy(); chk("quick_read_result", 32'h0, st[5]);
    cmd(8'h00, `FCS_OP_LP, 16'h0); rdy(); chk("prog_error_flag", 32'h1, st[3]);
    rdy(); chk("prog_error_flag", 32'h0, st[3]);
    cmd(`FCS_KEY, 6'h3F, 16'h0); rdy(); chk("prog_error_flag", 32'h1, st[3]);
    cmd(`FCS_KEY, `FCS_OP_UP, 16'h0); cmd(`FCS_KEY, `FCS_OP_WP, 16'h0);
    wb(1'b0, `FCS_OFF_STAT, 32'h0); chk("prog_error_flag", 32'h1, q[3]);
    rdy();
    lock <= 16'h0001; s0 = starts;
    cmd(`FCS_KEY, `FCS_OP_WP, 16'h0); rdy(); chk("lock_error_flag", 32'h1, st[2]);
    cmd(`FCS_KEY, `FCS_OP_EA, 16'h0); rdy(); chk("lock_error_flag", 32'h1, st[2]);
    chk("starts", s0, starts);
    rdy(); chk("lock_error_flag", 32'h0, st[2]);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reads();
    t_pbuf();
    t_cmds();
    chk("both0", 32'h0, both0);
    stop_test();
  end
  initial begin
    #3_000_000;
    n_fail++;
    stop_test();
  end
endmodule
